// ### src/ivm_vector_gen.sv
/*
 * reset and interrupt vector address generator for the core fetch logic.
 * picks the reset address after reset, and the vector address of the
 * lowest-numbered pending enabled source when the core can take one.
 * assumes request lines and control writes are synchronous to clk_in,
 * and that the core holds a request until it sees the acknowledge.
 */
// Function
// - reset starts execution at address zero
// - external requests 0..7 use vectors 2..9
// - timer 2 vectors at 0012 and 0014
// - timer 1 vectors 0016..001c and 0030
// - timer 0 vectors at 001e and 0020
// - spi and first usart vectors 0022..0028
// - converter, data memory, comparator at 002a..002e
// - timer 3 vectors at 0032..003a
// - second usart vectors at 003c..0040
// - two-wire and store-ready last, 35 vectors
// - legacy mode drops vectors 0030..0044
// - programmed boot fuse relocates first fetch
// - select bit adds boot base to vectors
// - table start independent of reset location
// - fuse zero programmed, one unprogrammed
// - timed unlock changes select, blocks interrupts
// - boot base derives from boot size fuses
`timescale 1ns/1ns
`default_nettype none
module ivm_vector_gen import ivm_pkg::*; #(
	parameter int NUM_SRC = IVM_NUM_SRC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// fuses
	input wire logic boot_reset_select_fuse_in,
	input wire logic [IVM_BSZ_W-1:0] boot_size_fuses_in,
	input wire logic legacy_mode_fuse_in,
	// core control register write port
	input wire logic ctrl_wr_in,
	input wire logic vector_table_select_in,
	input wire logic vector_change_unlock_in,
	// interrupt sources and core handshake
	input wire logic [NUM_SRC-1:0] irq_req_in,
	input wire logic global_int_enable_in,
	input wire logic core_ready_in,
	// program counter load
	output logic pc_load_out,
	output logic [IVM_ADDR_W-1:0] pc_addr_out,
	// acknowledge to the source
	output logic irq_ack_out,
	output logic [IVM_VEC_W-1:0] irq_vector_out,
	// control state
	output logic vector_table_select_out,
	output logic vector_change_unlock_out,
	output logic irq_blocked_out
);
	ivm_state_t state_reg;
	ivm_state_t state_next;
	logic boot_fuse_reg;
	logic legacy_reg;
	logic [2:0] unlock_cnt_reg;
	logic [2:0] hold_cnt_reg;
	logic [NUM_SRC-1:0] eligible;
	logic any_eligible;
	logic [IVM_VEC_W-1:0] win_idx;
	logic take_irq;

	ivm_boot_if bif();

	ivm_boot_base u_boot_base (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.bif(bif)
	);

	// lowest index pending source wins
	function automatic logic [IVM_VEC_W-1:0] ivm_first_set(input logic [NUM_SRC-1:0] v);
		logic [IVM_VEC_W-1:0] r;
		r = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IVM_VEC_W'(i);
			end
		end
		return r;
	endfunction

	// vector address of source index: table start plus two words per slot
	function automatic logic [IVM_ADDR_W-1:0] ivm_vec_addr(input logic [IVM_VEC_W-1:0] idx,
			input logic sel, input logic [IVM_ADDR_W-1:0] base);
		logic [IVM_ADDR_W-1:0] start;
		start = sel ? IVM_ADDR_W'(base + IVM_TABLE_OFFSET) : IVM_TABLE_OFFSET;
		return IVM_ADDR_W'(start + IVM_ADDR_W'(idx) * IVM_SLOT_WORDS);
	endfunction

	assign bif.boot_size = boot_size_fuses_in;

	// sources allowed to raise: legacy mode hides the upper vectors
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			eligible[i] = irq_req_in[i] && !(legacy_reg && (i >= IVM_LEGACY_FIRST_IDX));
		end
	end

	assign any_eligible = |eligible;
	assign win_idx = ivm_first_set(eligible);
	// accept only in run state and never in the acknowledge cycle, because the
	// source drops its request one edge late; the unlock sequence holds
	// interrupts off, including the very cycle in which the unlock is written
	assign take_irq = (state_reg == IVM_ST_RUN) && global_int_enable_in && core_ready_in &&
		any_eligible && !irq_blocked_out && !irq_ack_out &&
		!(ctrl_wr_in && vector_change_unlock_in);

	// sequence: capture fuses, load reset vector, then serve interrupts
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			IVM_ST_RESET: state_next = IVM_ST_LOAD;
			IVM_ST_LOAD: state_next = IVM_ST_RUN;
			IVM_ST_RUN: state_next = IVM_ST_RUN;
			default: state_next = IVM_ST_RESET;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= IVM_ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// fuse levels are caught in the first clocked cycle after release
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			boot_fuse_reg <= 1'b1;
			legacy_reg <= 1'b0;
		end else if (state_reg == IVM_ST_RESET) begin
			boot_fuse_reg <= boot_reset_select_fuse_in;
			legacy_reg <= legacy_mode_fuse_in;
		end
	end

	// program counter load for reset and accepted interrupts
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pc_load_out <= 1'b0;
			pc_addr_out <= IVM_RESET_ADDR;
		end else if (state_reg == IVM_ST_LOAD) begin
			pc_load_out <= 1'b1;
			if (boot_fuse_reg == IVM_FUSE_PROGRAMMED) begin
				pc_addr_out <= bif.boot_base;
			end else begin
				pc_addr_out <= IVM_RESET_ADDR;
			end
		end else if (take_irq) begin
			// reset load cannot meet an interrupt: take_irq needs run state
			pc_load_out <= 1'b1;
			pc_addr_out <= ivm_vec_addr(win_idx, vector_table_select_out, bif.boot_base);
		end else begin
			pc_load_out <= 1'b0;
		end
	end

	// acknowledge pulse with the vector number of the taken source
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_ack_out <= 1'b0;
			irq_vector_out <= '0;
		end else begin
			irq_ack_out <= take_irq;
			if (take_irq) begin
				irq_vector_out <= IVM_VEC_W'(win_idx + IVM_FIRST_IRQ_VEC);
			end
		end
	end

	// timed unlock: select changes only inside the open window
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			vector_table_select_out <= 1'b0;
			vector_change_unlock_out <= 1'b0;
			unlock_cnt_reg <= '0;
		end else if (ctrl_wr_in && vector_change_unlock_in) begin
			vector_change_unlock_out <= 1'b1;
			unlock_cnt_reg <= IVM_UNLOCK_CYCLES;
		end else if (ctrl_wr_in && (unlock_cnt_reg != 3'h0)) begin
			vector_table_select_out <= vector_table_select_in;
			vector_change_unlock_out <= 1'b0;
			unlock_cnt_reg <= '0;
		end else if (unlock_cnt_reg != 3'h0) begin
			unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
			vector_change_unlock_out <= (unlock_cnt_reg != 3'h1);
		end
	end

	// interrupt blocking across the whole window, last cycle included, and two cycles past the write
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_blocked_out <= 1'b0;
			hold_cnt_reg <= '0;
		end else if (ctrl_wr_in && vector_change_unlock_in) begin
			irq_blocked_out <= 1'b1;
			hold_cnt_reg <= '0;
		end else if (ctrl_wr_in && (unlock_cnt_reg != 3'h0)) begin
			// keep interrupts off until the instruction after the select write
			irq_blocked_out <= 1'b1;
			hold_cnt_reg <= IVM_POST_WRITE_HOLD;
		end else if (hold_cnt_reg != 3'h0) begin
			hold_cnt_reg <= hold_cnt_reg - 3'h1;
			irq_blocked_out <= 1'b1;
		end else begin
			irq_blocked_out <= (unlock_cnt_reg > 3'h1);
		end
	end
endmodule
`default_nettype wire

// ### src/ivm_pkg.sv
/*
 * constants for the reset and interrupt vector address generator:
 * table addresses, slot spacing, source count, unlock window timing.
 * assumes word addressing of program memory, 16-bit program counter.
 */
package ivm_pkg;
	localparam int IVM_ADDR_W = 16;
	localparam int IVM_NUM_SRC = 34; // interrupt sources, vectors 2..35
	localparam int IVM_NUM_VEC = 35; // reset vector plus the sources
	localparam int IVM_VEC_W = 6;
	localparam int IVM_BSZ_W = 2;
	localparam logic [IVM_ADDR_W-1:0] IVM_RESET_ADDR = 16'h0000;
	localparam logic [IVM_ADDR_W-1:0] IVM_TABLE_OFFSET = 16'h0002;
	localparam logic [IVM_ADDR_W-1:0] IVM_SLOT_WORDS = 16'h0002;
	localparam logic [IVM_ADDR_W-1:0] IVM_LEGACY_FIRST_ADDR = 16'h0030;
	localparam logic [IVM_ADDR_W-1:0] IVM_LAST_ADDR = 16'h0044;
	localparam logic [IVM_VEC_W-1:0] IVM_FIRST_IRQ_VEC = 6'h02;
	// source index of the first vector missing in legacy mode
	localparam int IVM_LEGACY_FIRST_IDX = 23;
	// unlock window length and post-write hold, in clock cycles
	localparam int IVM_UNLOCK_CYCLES_NUM = 4;
	localparam logic [2:0] IVM_UNLOCK_CYCLES = 3'h4;
	localparam logic [2:0] IVM_POST_WRITE_HOLD = 3'h1;
	localparam logic IVM_FUSE_PROGRAMMED = 1'b0;
	typedef enum logic [1:0] {
		IVM_ST_RESET = 2'b00,
		IVM_ST_LOAD = 2'b01,
		IVM_ST_RUN = 2'b10
	} ivm_state_t;
endpackage

// ### src/ivm_boot_if.sv
/*
 * carrier between the vector generator and the boot base decoder.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface ivm_boot_if;
	import ivm_pkg::*;
	logic [IVM_BSZ_W-1:0] boot_size;
	logic [IVM_ADDR_W-1:0] boot_base;
	modport requester (output boot_size, input boot_base);
	modport decoder (input boot_size, output boot_base);
endinterface
`default_nettype wire

// ### src/ivm_boot_base.sv
/*
 * decodes the boot size fuse setting into the boot flash start address.
 * assumes the fuse code is stable; result comes out of a register.
 */
`timescale 1ns/1ns
`default_nettype none
module ivm_boot_base import ivm_pkg::*; #(
	parameter logic [IVM_ADDR_W-1:0] BASE_SZ0 = 16'hf000,
	parameter logic [IVM_ADDR_W-1:0] BASE_SZ1 = 16'hf800,
	parameter logic [IVM_ADDR_W-1:0] BASE_SZ2 = 16'hfc00,
	parameter logic [IVM_ADDR_W-1:0] BASE_SZ3 = 16'hfe00
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// fuse code in, base address out
	ivm_boot_if.decoder bif
);
	// registered lookup of the boot section start
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bif.boot_base <= BASE_SZ0;
		end else begin
			case (bif.boot_size)
				2'h0: bif.boot_base <= BASE_SZ0;
				2'h1: bif.boot_base <= BASE_SZ1;
				2'h2: bif.boot_base <= BASE_SZ2;
				default: bif.boot_base <= BASE_SZ3;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### test/ivm_vector_gen_assertions.sv
/* port checks for the vector generator.
   assumes it is bound to ivm_vector_gen, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module ivm_vector_gen_assertions import ivm_pkg::*; #(
	parameter int NUM_SRC = IVM_NUM_SRC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// fuses and control writes
	input wire logic boot_reset_select_fuse_in,
	input wire logic legacy_mode_fuse_in,
	input wire logic ctrl_wr_in,
	input wire logic vector_table_select_in,
	input wire logic vector_change_unlock_in,
	// generator outputs
	input wire logic pc_load_out,
	input wire logic [IVM_ADDR_W-1:0] pc_addr_out,
	input wire logic irq_ack_out,
	input wire logic [IVM_VEC_W-1:0] irq_vector_out,
	input wire logic vector_table_select_out,
	input wire logic vector_change_unlock_out,
	input wire logic irq_blocked_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// interrupt load and acknowledge
	AST_ACK_PC: assert property (irq_ack_out |-> pc_load_out)
		else $error("ack without pc load");
	AST_ACK_ONE: assert property (irq_ack_out |=> !irq_ack_out)
		else $error("ack longer than one cycle");
	AST_ADDR: assert property (irq_ack_out && !vector_table_select_out |->
		pc_addr_out == 16'(irq_vector_out) * 16'h0002 - 16'h0002)
		else $error("vector address off table");
	AST_LEGACY: assert property (legacy_mode_fuse_in && irq_ack_out |->
		irq_vector_out < 6'h19) else $error("legacy vector taken");
	AST_NO_BLK_ACK: assert property (irq_ack_out |-> !$past(irq_blocked_out))
		else $error("ack while blocked");
	AST_RST_ZERO: assert property (pc_load_out && !irq_ack_out &&
		boot_reset_select_fuse_in |-> pc_addr_out == IVM_RESET_ADDR)
		else $error("reset load not at zero");
	// timed select change
	AST_UNLOCK: assert property (ctrl_wr_in && vector_change_unlock_in |=>
		vector_change_unlock_out && irq_blocked_out) else $error("unlock not opened");
	AST_SEL_SET: assert property (ctrl_wr_in && !vector_change_unlock_in &&
		vector_change_unlock_out |=> !vector_change_unlock_out &&
		vector_table_select_out == $past(vector_table_select_in) ##1 irq_blocked_out)
		else $error("select write in window mishandled");
	AST_SEL_KEEP: assert property (ctrl_wr_in && !vector_change_unlock_in &&
		!vector_change_unlock_out |=> $stable(vector_table_select_out))
		else $error("select changed without unlock");
	COV_BOOT_IRQ: cover property (irq_ack_out && vector_table_select_out);
	COV_WIN: cover property ($fell(vector_change_unlock_out));
	COV_RST: cover property (pc_load_out && !irq_ack_out);
endmodule
`default_nettype wire

// ### test/ivm_core_model.sv
/* core fetch model: holds requests until acknowledged, logs loads.
   assumes the generator shares its clock; the bench sets requests. */
`timescale 1ns/1ns
`default_nettype none
module ivm_core_model import ivm_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// bench controls: one-cycle raise mask, drop of all requests, slow core
	input wire logic [IVM_NUM_SRC-1:0] raise_in,
	input wire logic drop_all_in,
	input wire logic slow_in,
	// generator outputs
	input wire logic pc_load_in,
	input wire logic [IVM_ADDR_W-1:0] pc_addr_in,
	input wire logic irq_ack_in,
	input wire logic [IVM_VEC_W-1:0] irq_vector_in,
	// requests, readiness and the last load seen
	output var logic [IVM_NUM_SRC-1:0] irq_req_out,
	output logic core_ready_out,
	output var logic [IVM_ADDR_W-1:0] last_addr_out,
	output var logic [IVM_VEC_W-1:0] last_vec_out
);
	logic tick_reg;
	// slow mode is ready only every other cycle
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= !tick_reg;
		end
	end
	assign core_ready_out = !slow_in || tick_reg;
	// sources hold a request until the edge at which they see its acknowledge
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_req_out <= '0;
		end else if (drop_all_in) begin
			irq_req_out <= '0;
		end else begin
			irq_req_out <= irq_req_out | raise_in;
			if (irq_ack_in) begin
				irq_req_out[irq_vector_in - IVM_FIRST_IRQ_VEC] <= 1'b0;
			end
		end
	end
	// log loads; the marker left by reset shows a missing reset load
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			last_addr_out <= 16'h5a5a;
			last_vec_out <= '0;
		end else begin
			if (pc_load_in) begin
				last_addr_out <= pc_addr_in;
			end
			if (irq_ack_in) begin
				last_vec_out <= irq_vector_in;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/tb_top.sv
/* testbench: reset loads, full table, relocation, unlock, legacy.
   assumes the generator and core model of src and test. */
`timescale 1ns/1ns
`default_nettype none
module tb_top import ivm_pkg::*;;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic fuse = 1'b1, lgc = 1'b0, wr = 1'b0, sel = 1'b0, unl = 1'b0, gie = 1'b1;
	logic slow = 1'b0, drop = 1'b0;
	logic [1:0] bsz = 2'h0;
	logic [33:0] raise = '0;
	logic [15:0] base_tab [4] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfe00};
	int n_fail = 0, samples_checked = 0;
	wire logic ld, ack, sel_o, unl_o, blk, rdy;
	wire logic [15:0] addr, last_addr;
	wire logic [5:0] vec, last_vec;
	wire logic [33:0] req;
	always #5 clk_in = !clk_in;
	ivm_vector_gen u_dut (.clk_in, .sys_rst_in, .boot_reset_select_fuse_in(fuse),
		.boot_size_fuses_in(bsz), .legacy_mode_fuse_in(lgc), .ctrl_wr_in(wr),
		.vector_table_select_in(sel), .vector_change_unlock_in(unl), .irq_req_in(req),
		.global_int_enable_in(gie), .core_ready_in(rdy), .pc_load_out(ld),
		.pc_addr_out(addr), .irq_ack_out(ack), .irq_vector_out(vec),
		.vector_table_select_out(sel_o), .vector_change_unlock_out(unl_o),
		.irq_blocked_out(blk));
	ivm_core_model u_core (.clk_in, .sys_rst_in, .raise_in(raise), .drop_all_in(drop),
		.slow_in(slow), .pc_load_in(ld), .pc_addr_in(addr), .irq_ack_in(ack),
		.irq_vector_in(vec), .irq_req_out(req), .core_ready_out(rdy),
		.last_addr_out(last_addr), .last_vec_out(last_vec));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// reset for 20 cycles with the given fuses
	task automatic boot(input logic f, input logic [1:0] s, input logic l);
		sys_rst_in = 1'b1;
		fuse = f;
		bsz = s;
		lgc = l;
		repeat (20) @(negedge clk_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask
	// one control register write, with an idle edge before it
	task automatic ctl(input logic s, input logic u);
		@(negedge clk_in);
		wr = 1'b1;
		sel = s;
		unl = u;
		@(negedge clk_in);
		wr = 1'b0;
	endtask
	// raise a request for one cycle
	task automatic post(input int i);
		raise[i] = 1'b1;
		@(negedge clk_in);
		raise = '0;
	endtask
	// raise a request and wait a bounded time for its acknowledge
	task automatic fire(input int i);
		post(i);
		for (int n = 0; n < 40 && req[i]; n++) @(negedge clk_in);
	endtask
	initial begin
		boot(1'b1, 2'h0, 1'b0);
		check(last_addr, 16'h0000);
		gie = 1'b0;
		fire(3);
		check(16'(req[3]), 16'h0001);
		check(last_addr, 16'h0000);
		gie = 1'b1;
		fire(3);
		check(last_addr, 16'h0008);
		for (int i = 0; i < 34; i++) begin
			slow = i[0];
			fire(i);
			check(last_addr, 16'h0002 + 16'(2 * i));
			check(16'(last_vec), 16'(i + 2));
		end
		for (int s = 0; s < 4; s++) begin
			boot(1'b1, 2'(s), 1'b0);
			ctl(1'b0, 1'b1);
			check(16'(blk), 16'h0001);
			post(0);
			ctl(1'b1, 1'b0);
			check(16'(req[0]), 16'h0001);
			fire(0);
			check(last_addr, base_tab[s] + 16'h0002);
			ctl(1'b0, 1'b0);
			check(16'(sel_o), 16'h0001);
		end
		boot(1'b0, 2'h3, 1'b0);
		check(last_addr, base_tab[3]);
		fire(0);
		check(last_addr, 16'h0002);
		ctl(1'b0, 1'b1);
		repeat (5) @(negedge clk_in);
		ctl(1'b1, 1'b0);
		check(16'(sel_o), 16'h0000);
		check(16'(blk), 16'h0000);
		boot(1'b1, 2'h0, 1'b1);
		fire(23);
		check(16'(req[23]), 16'h0001);
		drop = 1'b1;
		@(negedge clk_in);
		drop = 1'b0;
		fire(22);
		check(last_addr, 16'h002e);
		end_of_test();
	end
	// watchdog
	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end
endmodule
bind ivm_vector_gen ivm_vector_gen_assertions #(.NUM_SRC(NUM_SRC)) u_chk (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .boot_reset_select_fuse_in(boot_reset_select_fuse_in),
	.legacy_mode_fuse_in(legacy_mode_fuse_in), .ctrl_wr_in(ctrl_wr_in),
	.vector_table_select_in(vector_table_select_in),
	.vector_change_unlock_in(vector_change_unlock_in), .pc_load_out(pc_load_out),
	.pc_addr_out(pc_addr_out), .irq_ack_out(irq_ack_out), .irq_vector_out(irq_vector_out),
	.vector_table_select_out(vector_table_select_out),
	.vector_change_unlock_out(vector_change_unlock_out), .irq_blocked_out(irq_blocked_out));
`default_nettype wire
